// >>> tws_pkg.sv
// shared constants for the two-wire register port
package tws_pkg;
	localparam logic [4:0] DEV_ADDR_HI = 5'h13;
	localparam logic [7:0] REG_TOP = 8'h1d;
	localparam int REG_COUNT = 30;
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam int CLK_MHZ = 100;
	localparam int SCL_HALF_NS = 2500;
	localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int FILT_LEN = 3;
	typedef enum logic [3:0] {
		MS_IDLE = 4'h0,
		MS_START = 4'h1,
		MS_BIT_LO = 4'h2,
		MS_BIT_HI = 4'h3,
		MS_STOP_LO = 4'h4,
		MS_STOP_HI = 4'h5,
		MS_STOP_END = 4'h6,
		MS_RS_LO = 4'h7,
		MS_RS_HI = 4'h8
	} tws_mst_e;
endpackage

// >>> tws_bus_if.sv
// two-wire bus carrier joining master and slave ends
`timescale 1ns/1ps
interface tws_bus_if;
	logic scl_out;
	logic scl_oe_n;
	logic sda_m_out;
	logic sda_m_oe_n;
	logic sda_s_out;
	logic sda_s_oe_n;
	logic scl;
	logic sda;
	// open drain with pull-up: low wins when any party drives
	assign scl = scl_oe_n ? 1'b1 : scl_out;
	assign sda = (sda_m_oe_n ? 1'b1 : sda_m_out) &
		(sda_s_oe_n ? 1'b1 : sda_s_out);
	modport master (
		output scl_out,
		output scl_oe_n,
		output sda_m_out,
		output sda_m_oe_n,
		input scl,
		input sda
	);
	modport slave (
		output sda_s_out,
		output sda_s_oe_n,
		input scl,
		input sda
	);
endinterface

// >>> tws_slave.sv
// slave end: register port on the two-wire bus
`timescale 1ns/1ps
module tws_slave #(
	parameter int FILT = tws_pkg::FILT_LEN
) (
	input wire logic clock,
	input wire logic rst,
	tws_bus_if.slave bus,
	input wire logic [1:0] addr_select_pins,
	output logic [7:0] wr_data,
	output logic [7:0] wr_addr,
	output logic wr_strobe,
	output logic [7:0] cur_addr
);
	typedef enum logic [2:0] {
		SS_IDLE = 3'h0,
		SS_ADDR = 3'h1,
		SS_REG = 3'h2,
		SS_WDATA = 3'h3,
		SS_RDATA = 3'h4,
		SS_SKIP = 3'h5
	} tws_slv_e;
	logic [1:0] scl_sync_reg, sda_sync_reg;
	logic [1:0] scl_sync_next, sda_sync_next;
	logic [FILT-1:0] scl_hist_reg, sda_hist_reg;
	logic [FILT-1:0] scl_hist_next, sda_hist_next;
	logic scl_f_reg, sda_f_reg, scl_f_next, sda_f_next;
	tws_slv_e st_reg, st_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] addr_reg, addr_next;
	logic rd_reg, rd_next;
	logic ack_reg, ack_next;
	logic sda_drv_reg, sda_drv_next;
	logic [7:0] mem_reg [tws_pkg::REG_COUNT];
	logic [7:0] wd_reg, wd_next, wa_reg, wa_next;
	logic ws_reg, ws_next;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic [7:0] rbyte;
	logic [7:0] inc_addr;

	// only the filtered copies feed edge detection
	always_comb begin
		scl_sync_next = {scl_sync_reg[0], bus.scl};
		sda_sync_next = {sda_sync_reg[0], bus.sda};
		scl_hist_next = {scl_hist_reg[FILT-2:0], scl_sync_reg[1]};
		sda_hist_next = {sda_hist_reg[FILT-2:0], sda_sync_reg[1]};
		scl_f_next = scl_f_reg;
		sda_f_next = sda_f_reg;
		if (&scl_hist_reg)
			scl_f_next = 1'b1;
		else if (~|scl_hist_reg)
			scl_f_next = 1'b0;
		if (&sda_hist_reg)
			sda_f_next = 1'b1;
		else if (~|sda_hist_reg)
			sda_f_next = 1'b0;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_hist_reg <= '1;
			sda_hist_reg <= '1;
			scl_f_reg <= 1'b1;
			sda_f_reg <= 1'b1;
		end else begin
			scl_sync_reg <= scl_sync_next;
			sda_sync_reg <= sda_sync_next;
			scl_hist_reg <= scl_hist_next;
			sda_hist_reg <= sda_hist_next;
			scl_f_reg <= scl_f_next;
			sda_f_reg <= sda_f_next;
		end
	end

	assign scl_rise = scl_f_next & ~scl_f_reg;
	assign scl_fall = ~scl_f_next & scl_f_reg;
	assign start_c = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
	assign stop_c = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;
	assign rbyte = (addr_reg <= tws_pkg::REG_TOP) ?
		mem_reg[addr_reg[4:0]] : 8'h00;
	assign inc_addr = (addr_reg >= tws_pkg::REG_TOP) ?
		tws_pkg::REG_TOP : addr_reg + 8'h01;

	always_comb begin
		st_next = st_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		addr_next = addr_reg;
		rd_next = rd_reg;
		ack_next = ack_reg;
		sda_drv_next = sda_drv_reg;
		wd_next = wd_reg;
		wa_next = wa_reg;
		ws_next = 1'b0;
		if (stop_c) begin
			// partial byte simply dropped
			st_next = SS_IDLE;
			sda_drv_next = 1'b0;
		end else if (start_c) begin
			st_next = SS_ADDR;
			// the clock fall that follows a start ends no bit; wraps to 0
			bit_next = '1;
			sda_drv_next = 1'b0;
		end else if (scl_rise && st_reg != SS_IDLE && st_reg != SS_SKIP) begin
			// own read data shifts on the fall only, never sampled back
			if (st_reg == SS_RDATA) begin
				if (bit_reg == tws_pkg::ACK_BIT)
					ack_next = ~sda_f_reg;
			end else if (bit_reg < tws_pkg::ACK_BIT) begin
				sh_next = {sh_reg[6:0], sda_f_reg};
			end
		end else if (scl_fall && st_reg != SS_IDLE && st_reg != SS_SKIP) begin
			sda_drv_next = 1'b0;
			if (bit_reg == tws_pkg::LAST_BIT) begin
				bit_next = tws_pkg::ACK_BIT;
				case (st_reg)
					SS_ADDR: begin
						ack_next = (sh_reg[7:3] == tws_pkg::DEV_ADDR_HI) &&
							(sh_reg[2:1] == addr_select_pins);
						rd_next = sh_reg[0];
						sda_drv_next = ack_next;
					end
					SS_REG: begin
						ack_next = sh_reg <= tws_pkg::REG_TOP;
						if (ack_next)
							addr_next = sh_reg;
						sda_drv_next = ack_next;
					end
					SS_WDATA: begin
						wd_next = sh_reg;
						wa_next = addr_reg;
						ws_next = 1'b1;
						addr_next = inc_addr;
						sda_drv_next = 1'b1;
					end
					SS_RDATA: begin
						addr_next = inc_addr;
						sda_drv_next = 1'b0;
					end
					default: begin
						sda_drv_next = 1'b0;
					end
				endcase
			end else if (bit_reg == tws_pkg::ACK_BIT) begin
				bit_next = 4'h0;
				case (st_reg)
					SS_ADDR: begin
						if (!ack_reg)
							st_next = SS_SKIP;
						else if (rd_reg)
							st_next = SS_RDATA;
						else
							st_next = SS_REG;
					end
					SS_REG: st_next = ack_reg ? SS_WDATA : SS_SKIP;
					SS_WDATA: st_next = SS_WDATA;
					SS_RDATA: st_next = ack_reg ? SS_RDATA : SS_SKIP;
					default: st_next = SS_SKIP;
				endcase
				if (st_next == SS_RDATA) begin
					sh_next = rbyte;
					sda_drv_next = ~rbyte[7];
				end
			end else begin
				bit_next = bit_reg + 4'h1;
				if (st_reg == SS_RDATA) begin
					sh_next = {sh_reg[6:0], 1'b0};
					sda_drv_next = ~sh_reg[6];
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg <= SS_IDLE;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			addr_reg <= 8'h00;
			rd_reg <= 1'b0;
			ack_reg <= 1'b0;
			sda_drv_reg <= 1'b0;
			wd_reg <= 8'h00;
			wa_reg <= 8'h00;
			ws_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			addr_reg <= addr_next;
			rd_reg <= rd_next;
			ack_reg <= ack_next;
			sda_drv_reg <= sda_drv_next;
			wd_reg <= wd_next;
			wa_reg <= wa_next;
			ws_reg <= ws_next;
		end
	end

	// register store; reset clears every entry to 8'h00
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < tws_pkg::REG_COUNT; i++)
				mem_reg[i] <= 8'h00;
		end else if (ws_next) begin
			mem_reg[wa_next[4:0]] <= wd_next;
		end
	end

	assign bus.sda_s_out = 1'b0;
	assign bus.sda_s_oe_n = ~sda_drv_reg;
	assign wr_data = wd_reg;
	assign wr_addr = wa_reg;
	assign wr_strobe = ws_reg;
	assign cur_addr = addr_reg;
endmodule

// >>> tws_master.sv
// master end: drives the serial clock and issues byte operations
`timescale 1ns/1ps
module tws_master #(
	parameter int HALF = tws_pkg::SCL_HALF_CYC
) (
	input wire logic clock,
	input wire logic rst,
	tws_bus_if.master bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_start,
	input wire logic cmd_stop,
	input wire logic cmd_read,
	input wire logic cmd_nack,
	input wire logic [7:0] cmd_data,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_ack
);
	tws_pkg::tws_mst_e st_reg, st_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [3:0] bit_reg, bit_next;
	logic [8:0] sh_reg, sh_next;
	logic [8:0] in_reg, in_next;
	logic scl_reg, scl_next, sda_reg, sda_next;
	logic stop_reg, stop_next, rd_reg, rd_next;
	logic started_reg, started_next;
	logic rv_reg, rv_next;
	logic [1:0] sda_s_reg;
	logic tick;

	assign tick = cnt_reg == 16'(HALF - 1);
	assign cmd_ready = st_reg == tws_pkg::MS_IDLE;

	always_comb begin
		st_next = st_reg;
		cnt_next = tick ? 16'h0000 : cnt_reg + 16'h0001;
		bit_next = bit_reg;
		sh_next = sh_reg;
		in_next = in_reg;
		scl_next = scl_reg;
		sda_next = sda_reg;
		stop_next = stop_reg;
		rd_next = rd_reg;
		started_next = started_reg;
		rv_next = 1'b0;
		case (st_reg)
			tws_pkg::MS_IDLE: begin
				cnt_next = 16'h0000;
				if (cmd_valid) begin
					// byte plus ack slot, msb first
					sh_next = cmd_read ? {8'hff, cmd_nack} : {cmd_data, 1'b1};
					stop_next = cmd_stop;
					rd_next = cmd_read;
					bit_next = 4'h0;
					if (cmd_start && started_reg)
						st_next = tws_pkg::MS_RS_LO;
					else if (cmd_start)
						st_next = tws_pkg::MS_START;
					else
						st_next = tws_pkg::MS_BIT_LO;
				end
			end
			tws_pkg::MS_RS_LO: if (tick) begin
				scl_next = 1'b0;
				sda_next = 1'b1;
				st_next = tws_pkg::MS_RS_HI;
			end
			tws_pkg::MS_RS_HI: if (tick) begin
				scl_next = 1'b1;
				st_next = tws_pkg::MS_START;
			end
			tws_pkg::MS_START: if (tick) begin
				sda_next = 1'b0;
				started_next = 1'b1;
				st_next = tws_pkg::MS_BIT_LO;
			end
			tws_pkg::MS_BIT_LO: if (tick) begin
				scl_next = 1'b0;
				sda_next = sh_reg[8];
				st_next = tws_pkg::MS_BIT_HI;
			end
			tws_pkg::MS_BIT_HI: if (tick) begin
				scl_next = 1'b1;
				in_next = {in_reg[7:0], sda_s_reg[1]};
				sh_next = {sh_reg[7:0], 1'b1};
				if (bit_reg == tws_pkg::ACK_BIT) begin
					rv_next = 1'b1;
					st_next = stop_reg ? tws_pkg::MS_STOP_LO : tws_pkg::MS_IDLE;
				end else begin
					bit_next = bit_reg + 4'h1;
					st_next = tws_pkg::MS_BIT_LO;
				end
			end
			tws_pkg::MS_STOP_LO: if (tick) begin
				scl_next = 1'b0;
				sda_next = 1'b0;
				st_next = tws_pkg::MS_STOP_HI;
			end
			tws_pkg::MS_STOP_HI: if (tick) begin
				scl_next = 1'b1;
				st_next = tws_pkg::MS_STOP_END;
			end
			tws_pkg::MS_STOP_END: if (tick) begin
				sda_next = 1'b1;
				started_next = 1'b0;
				st_next = tws_pkg::MS_IDLE;
			end
			default: st_next = tws_pkg::MS_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg <= tws_pkg::MS_IDLE;
			cnt_reg <= 16'h0000;
			bit_reg <= 4'h0;
			sh_reg <= 9'h1ff;
			in_reg <= 9'h000;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			stop_reg <= 1'b0;
			rd_reg <= 1'b0;
			started_reg <= 1'b0;
			rv_reg <= 1'b0;
			sda_s_reg <= 2'h3;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			in_reg <= in_next;
			scl_reg <= scl_next;
			sda_reg <= sda_next;
			stop_reg <= stop_next;
			rd_reg <= rd_next;
			started_reg <= started_next;
			rv_reg <= rv_next;
			sda_s_reg <= {sda_s_reg[0], bus.sda};
		end
	end

	// released lines rely on the pull-up for high
	assign bus.scl_out = 1'b0;
	assign bus.scl_oe_n = scl_reg;
	assign bus.sda_m_out = 1'b0;
	assign bus.sda_m_oe_n = sda_reg;
	assign rsp_valid = rv_reg;
	assign rsp_data = in_reg[8:1];
	assign rsp_ack = ~in_reg[0];
endmodule

// >>> tws_chk.sv
// assertions on the shared bus between master and slave ends
`timescale 1ns/1ps
module tws_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_oe_n,
	input wire logic [1:0] addr_select_pins
);
	logic scl_reg, sda_reg, act_reg, dir_reg, ign_reg, end_reg;
	logic [3:0] cnt_reg;
	logic [1:0] byt_reg;
	logic [7:0] sh_reg;
	logic rise, st, sp, ack9, hit;
	always_comb begin
		rise = scl & ~scl_reg;
		st = scl & scl_reg & sda_reg & ~sda;
		sp = scl & scl_reg & ~sda_reg & sda;
		ack9 = rise & act_reg & (cnt_reg == 4'h8);
		hit = sh_reg[7:1] == {tws_pkg::DEV_ADDR_HI, addr_select_pins};
	end
	// bit and byte position as seen on the wire; idle bus after reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			{act_reg, dir_reg, ign_reg, end_reg} <= 4'h0;
			cnt_reg <= 4'h0;
			byt_reg <= 2'h0;
			sh_reg <= 8'h00;
		end else begin
			scl_reg <= scl;
			sda_reg <= sda;
			if (rise)
				sh_reg <= {sh_reg[6:0], sda};
			if (st | sp)
				cnt_reg <= 4'h0;
			else if (rise)
				cnt_reg <= (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
			if (st | sp)
				act_reg <= st;
			// saturates so later data bytes all look alike
			if (st)
				byt_reg <= 2'h0;
			else if (rise & cnt_reg == 4'h9 & byt_reg != 2'h2)
				byt_reg <= byt_reg + 2'h1;
			if (ack9 & byt_reg == 2'h0)
				dir_reg <= sh_reg[0];
			if (st | sp)
				ign_reg <= 1'b0;
			else if (ack9 & byt_reg == 2'h0 & ~hit)
				ign_reg <= 1'b1;
			if (st | sp)
				end_reg <= 1'b0;
			else if (ack9 & byt_reg != 2'h0 & dir_reg & sda & ~ign_reg)
				end_reg <= 1'b1;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence s_stop;
		scl && scl_reg && !sda_reg && sda;
	endsequence
	sequence s_addr_ack;
		ack9 && byt_reg == 2'h0;
	endsequence
	sequence s_base_ack;
		ack9 && byt_reg == 2'h1 && !dir_reg && !ign_reg;
	endsequence
	property p_drive_low;
		$changed(sda_s_oe_n) |-> !scl;
	endproperty
	property p_addr_quiet;
		act_reg && byt_reg == 2'h0 && cnt_reg < 4'h8 |-> sda_s_oe_n;
	endproperty
	property p_ack_hit;
		s_addr_ack ##0 hit |-> !sda;
	endproperty
	property p_ack_miss;
		s_addr_ack ##0 !hit |-> sda;
	endproperty
	property p_ignore;
		ign_reg |-> sda_s_oe_n;
	endproperty
	property p_base_ok;
		s_base_ack ##0 sh_reg <= tws_pkg::REG_TOP |-> !sda;
	endproperty
	property p_base_bad;
		s_base_ack ##0 sh_reg > tws_pkg::REG_TOP |-> sda;
	endproperty
	property p_stop;
		s_stop |=> sda_s_oe_n [*8];
	endproperty
	property p_rd_end;
		end_reg |-> sda_s_oe_n;
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("slave data moved while clock high");
	a_addr_quiet: assert property (p_addr_quiet)
		else $error("slave drove during address byte");
	a_ack_hit: assert property (p_ack_hit)
		else $error("own address not acknowledged");
	a_ack_miss: assert property (p_ack_miss)
		else $error("foreign address acknowledged");
	a_ignore: assert property (p_ignore)
		else $error("slave drove after foreign address");
	a_base_ok: assert property (p_base_ok)
		else $error("valid base not acknowledged");
	a_base_bad: assert property (p_base_bad)
		else $error("base above top acknowledged");
	a_stop: assert property (p_stop)
		else $error("slave drove after stop");
	a_rd_end: assert property (p_rd_end)
		else $error("slave drove after master nack");
endmodule

// >>> two_wire_register_slave_port_tb.sv
// self-checking bench: master and slave ends joined on one bus
`timescale 1ns/1ps
module two_wire_register_slave_port_tb;
	localparam logic [3:0] S = 4'h8, P = 4'h4, R = 4'h2, N = 4'h1;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic [3:0] flg = 4'h0;
	logic [7:0] cmd_data = 8'h00;
	logic [1:0] sel = 2'h1;
	logic cmd_ready, rsp_valid, rsp_ack, wr_strobe, a;
	logic [7:0] rsp_data, wr_data, wr_addr, q, cur_addr;
	int ptr = 0;
	int err_total = 0;
	int checks = 0;
	int cycles = 0;
	integer seed = 32'h647f2320;
	int mem [0:29];
	int exp_q [$];
	tws_bus_if bus();
	tws_master #(.HALF(20)) tws_master_inst (.clock(clock), .rst(rst),
		.bus(bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_start(flg[3]), .cmd_stop(flg[2]), .cmd_read(flg[1]),
		.cmd_nack(flg[0]), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_ack(rsp_ack));
	tws_slave tws_slave_inst (.clock(clock), .rst(rst), .bus(bus),
		.addr_select_pins(sel), .wr_data(wr_data), .wr_addr(wr_addr),
		.wr_strobe(wr_strobe), .cur_addr(cur_addr));
	tws_chk tws_chk_inst (.clock(clock), .rst(rst), .scl(bus.scl),
		.sda(bus.sda), .sda_s_oe_n(bus.sda_s_oe_n),
		.addr_select_pins(sel));
	initial forever #5 clock = ~clock;
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk_ack(input logic e, input logic g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t ack %b expected %b", $time, g, e);
		end
	endtask
	task automatic chk_val(input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t value %h expected %h", $time, g, e);
		end
	endtask
	// the ceiling is about two and a half to three times the planned traffic
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			err_total++;
			complete_run;
		end
	end
	// strobe stands one cycle; looked at mid-cycle, away from its edge
	always @(negedge clock)
		if (wr_strobe === 1'b1)
			chk_val(exp_q.size() ? 16'(exp_q.pop_front()) : 16'hffff,
				{wr_addr, wr_data});
	function automatic int lim(input int x);
		return x > 29 ? 29 : x;
	endfunction
	task automatic xfer(input logic [3:0] f, input logic [7:0] d);
		int n;
		do @(negedge clock); while (cmd_ready !== 1'b1);
		@(posedge clock);
		cmd_valid <= 1'b1;
		flg <= f;
		cmd_data <= d;
		@(posedge clock);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (rsp_valid !== 1'b1 && n < 2000);
		if (rsp_valid !== 1'b1) begin
			err_total++;
			$display("ERROR %0t no response from master", $time);
		end
		a = rsp_ack;
		q = rsp_data;
	endtask
	task automatic wr(input int base, input int n);
		int d;
		xfer(S, {tws_pkg::DEV_ADDR_HI, sel, 1'b0});
		chk_ack(1'b1, a);
		xfer(n == 0 ? P : 4'h0, 8'(base));
		chk_ack(base <= 29, a);
		for (int i = 0; i < n; i++) begin
			d = $random(seed) & 255;
			mem[lim(base + i)] = d;
			exp_q.push_back({8'(lim(base + i)), 8'(d)});
			xfer(i == n - 1 ? P : 4'h0, 8'(d));
			chk_ack(1'b1, a);
		end
		// a refused base leaves the pointer where it was
		if (base <= 29)
			ptr = lim(base + n);
		chk_val(16'(ptr), {8'h00, cur_addr});
	endtask
	task automatic rd(input int base, input int n);
		xfer(S, {tws_pkg::DEV_ADDR_HI, sel, 1'b0});
		xfer(4'h0, 8'(base));
		xfer(S, {tws_pkg::DEV_ADDR_HI, sel, 1'b1});
		chk_ack(1'b1, a);
		for (int i = 0; i < n; i++) begin
			xfer(i == n - 1 ? P | R | N : R, 8'h00);
			chk_val(16'(mem[lim(base + i)]), {8'h00, q});
		end
		ptr = lim(base + n);
		chk_val(16'(ptr), {8'h00, cur_addr});
	endtask
	initial begin
		foreach (mem[i])
			mem[i] = 0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		xfer(S, {tws_pkg::DEV_ADDR_HI, ~sel, 1'b0});
		chk_ack(1'b0, a);
		xfer(P, 8'h5a);
		chk_ack(1'b0, a);
		$display("test foreign address done");
		wr(8'h1b, 4);
		rd(8'h1b, 3);
		$display("test saturating burst done");
		wr(8'h1e, 0);
		wr(8'hff, 0);
		$display("test base out of range done");
		// random straps, bases and write lengths, bases kept below the top on writes and reads
		repeat (4) begin
			@(posedge clock);
			sel <= 2'($random(seed));
			@(posedge clock);
			wr({$random(seed)} % 28, 1 + {$random(seed)} % 3);
			rd({$random(seed)} % 28, 3);
		end
		chk_val(16'h0000, 16'(exp_q.size()));
		$display("test random traffic done");
		complete_run;
	end
endmodule
